//--- hw/sfp_pkg.sv
// Shared constants for the serial FIFO port control block
package sfp_pkg;
   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] SFP_OFF_CTRL   = 8'h00;
   localparam logic [7:0] SFP_OFF_MSTOP  = 8'h04;
   localparam logic [7:0] SFP_OFF_TXDATA = 8'h08;
   localparam logic [7:0] SFP_OFF_LSTAT  = 8'h0C;
   localparam logic [7:0] SFP_OFF_TRIG   = 8'h10;
   localparam logic [7:0] SFP_OFF_RXDATA = 8'h14;
   localparam logic [7:0] SFP_OFF_ISTAT  = 8'h18;
   localparam logic [7:0] SFP_OFF_IMASK  = 8'h1C;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int SFP_CTL_TX_LOW_IRQ_ON   = 7;
   localparam int SFP_CTL_RX_IRQ_ON       = 6;
   localparam int SFP_CTL_TRANSMIT_ON     = 5;
   localparam int SFP_CTL_RX_ON           = 4;
   localparam int SFP_CTL_RX_FAULT_IRQ_ON = 3;
   localparam int SFP_CTL_CLK_SEL_HI      = 1;
   localparam int SFP_CTL_CLK_SEL_LO      = 0;
   localparam int SFP_MSTOP_SERIAL_UNIT   = 6;
   // Line status bits
   localparam int SFP_LS_TX_DONE  = 6;
   localparam int SFP_LS_TX_BELOW = 5;
   localparam int SFP_LS_BREAK    = 4;
   localparam int SFP_LS_FRAMING  = 3;
   localparam int SFP_LS_RX_FULL  = 1;
   localparam int SFP_LS_CNT_LO   = 8;
   // Interrupt status / mask bits
   localparam int SFP_IRQ_TX_LOW  = 0;
   localparam int SFP_IRQ_RX_FULL = 1;
   localparam int SFP_IRQ_FAULT   = 2;
   localparam int SFP_IRQ_BREAK   = 3;

   // ------------------------------------------------------------------
   // Reset values and fixed figures
   // ------------------------------------------------------------------
   localparam logic [15:0] SFP_CTRL_RESET  = 16'h0000;
   localparam logic [15:0] SFP_CTRL_MASK   = 16'h00FB;
   localparam logic [7:0]  SFP_MSTOP_RESET = 8'h00;
   localparam logic [4:0]  SFP_TRIG_RESET  = 5'h02;
   localparam logic [1:0]  SFP_CLK_INTERNAL = 2'h0;
   localparam logic [3:0]  SFP_TX_LAST_BIT  = 4'h9;
   localparam logic [3:0]  SFP_RX_STOP_BIT  = 4'h9;
endpackage : sfp_pkg

//--- hw/sfp_port.sv
// Serial port control, transmit FIFO, serial engines and Avalon-MM registers
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// (R1) Tx-low request only while control bit 7
// (R2) Bit 6 clear masks receive, error, break
// (R3) Bit 5 gates transmitter shifting
// (R4) Bit 4 clear stops frame reception
// (R5) Bit 3 clear masks error, break requests
// (R6) Clock select 00: internal, pin ignored
// (R7) Stop bit 6 set freezes the port
// (R8) Tx-low flag when count below trigger
// (R9) Tx-done flag when all bytes sent
// (R10) Sixteen byte FIFO, full writes dropped
// (R11) Tx-low output is flag AND enable AND not stopped
module sfp_port
   import sfp_pkg::*;
#(
   parameter int BAUD_DIV = 130,
   parameter int DEPTH    = 16
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             txd,
   input  wire logic        rxd,
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   output logic             tx_low_irq,
   output logic             rx_fifo_full_irq,
   output logic             rx_fault_irq,
   output logic             line_break_irq,
   output logic             irq
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                  ack;
      logic [31:0]           rdata;
      logic [15:0]           ctrl;
      logic [7:0]            mstop;
      logic [4:0]            trig;
      logic [3:0]            istat;
      logic [3:0]            imask;
      logic [DEPTH-1:0][7:0] mem;
      logic [3:0]            wp;
      logic [3:0]            rp;
      logic [4:0]            cnt;
      logic                  txbusy;
      logic [8:0]            txsh;
      logic [3:0]            txbit;
      logic [15:0]           txbd;
      logic                  txd;
      logic                  rxs1;
      logic                  rxs2;
      logic                  rxbusy;
      logic [3:0]            rxbit;
      logic [15:0]           rxbd;
      logic [7:0]            rxsh;
      logic [7:0]            rxdat;
      logic                  rxfull;
      logic                  ferr;
      logic                  brk;
   } sfp_state_t;

   localparam logic [15:0] BD_FULL = 16'(BAUD_DIV - 1);
   localparam logic [15:0] BD_HALF = 16'(BAUD_DIV / 2);
   localparam logic [4:0]  CNT_MAX = 5'(DEPTH);

   sfp_state_t  s;
   sfp_state_t  next_s;
   logic        rst_meta;
   logic        rst_sync;
   logic        run;
   logic        below;
   logic        done;
   logic [3:0]  req;
   logic [31:0] bmask;
   logic        req_any;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] lstat;

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ------------------------------------------------------------------
   // Derived levels
   // ------------------------------------------------------------------
   always_comb begin
      // (R7) Module stop gate
      run   = ~s.mstop[SFP_MSTOP_SERIAL_UNIT];
      // (R8) Count below trigger
      below = (s.cnt < s.trig);
      // (R9) Idle and drained
      done  = (s.cnt == 5'h00) && !s.txbusy;
      bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      req_any = avs_read | avs_write;
      wr_go   = avs_write & s.ack;
      rd_go   = avs_read & s.ack;
      lstat   = 32'h0000_0000;
      lstat[SFP_LS_TX_DONE]  = done;
      lstat[SFP_LS_TX_BELOW] = below;
      lstat[SFP_LS_BREAK]    = s.brk;
      lstat[SFP_LS_FRAMING]  = s.ferr;
      lstat[SFP_LS_RX_FULL]  = s.rxfull;
      lstat[SFP_LS_CNT_LO +: 5] = s.cnt;
   end

   // ------------------------------------------------------------------
   // Interrupt requests
   // ------------------------------------------------------------------
   always_comb begin
      // (R1) Enable gates tx-low
      // (R11) Flag AND enable AND run
      req[SFP_IRQ_TX_LOW]  = run & s.ctrl[SFP_CTL_TX_LOW_IRQ_ON] & below;
      // (R2) Receive group enable
      req[SFP_IRQ_RX_FULL] = run & s.ctrl[SFP_CTL_RX_IRQ_ON] & s.rxfull;
      // (R5) Fault and break enable
      req[SFP_IRQ_FAULT]   = run & s.ctrl[SFP_CTL_RX_IRQ_ON]
                             & s.ctrl[SFP_CTL_RX_FAULT_IRQ_ON] & s.ferr;
      req[SFP_IRQ_BREAK]   = run & s.ctrl[SFP_CTL_RX_IRQ_ON]
                             & s.ctrl[SFP_CTL_RX_FAULT_IRQ_ON] & s.brk;
   end

   assign tx_low_irq       = req[SFP_IRQ_TX_LOW];
   assign rx_fifo_full_irq = req[SFP_IRQ_RX_FULL];
   assign rx_fault_irq     = req[SFP_IRQ_FAULT];
   assign line_break_irq   = req[SFP_IRQ_BREAK];
   assign irq              = |(s.istat & s.imask);
   assign avs_waitrequest  = req_any & ~s.ack;
   assign avs_readdata     = s.rdata;
   assign txd              = s.txd;
   // (R6) Clock pin kept as an ignored input
   assign sck_out          = 1'b0;
   assign sck_oe           = 1'b0;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_s = s;
      // Bus: answer one cycle after the request appears
      next_s.ack = req_any & ~s.ack;
      if (req_any && !s.ack) begin
         unique case (avs_address)
            SFP_OFF_CTRL:   next_s.rdata = {16'h0000, s.ctrl};
            SFP_OFF_MSTOP:  next_s.rdata = {24'h000000, s.mstop};
            SFP_OFF_LSTAT:  next_s.rdata = lstat;
            SFP_OFF_TRIG:   next_s.rdata = {27'h0000000, s.trig};
            SFP_OFF_RXDATA: next_s.rdata = {24'h000000, s.rxdat};
            SFP_OFF_ISTAT:  next_s.rdata = {28'h0000000, s.istat};
            SFP_OFF_IMASK:  next_s.rdata = {28'h0000000, s.imask};
            default:        next_s.rdata = 32'h0000_0000;
         endcase
      end

      // Software clears come first so that a hardware set in the same cycle wins
      if (wr_go && avs_address == SFP_OFF_LSTAT && avs_byteenable[0]) begin
         if (avs_writedata[SFP_LS_BREAK]) begin
            next_s.brk = 1'b0;
         end
         if (avs_writedata[SFP_LS_FRAMING]) begin
            next_s.ferr = 1'b0;
         end
      end
      // Reading the received byte frees the holding register
      if (rd_go && avs_address == SFP_OFF_RXDATA) begin
         next_s.rxfull = 1'b0;
      end

      // Serial engines hold while the unit is stopped
      if (run) begin
         // Transmitter
         // (R3) Transmit enable gates shifting
         if (!s.ctrl[SFP_CTL_TRANSMIT_ON]) begin
            next_s.txbusy = 1'b0;
            next_s.txd    = 1'b1;
         end else if (!s.txbusy) begin
            if (s.cnt != 5'h00) begin
               next_s.txbusy = 1'b1;
               next_s.txsh   = {1'b1, s.mem[s.rp]};
               next_s.txd    = 1'b0;
               next_s.txbit  = 4'h0;
               next_s.txbd   = BD_FULL;
               next_s.rp     = s.rp + 4'h1;
               next_s.cnt    = s.cnt - 5'h01;
            end
         end else if (s.txbd != 16'h0000) begin
            next_s.txbd = s.txbd - 16'h0001;
         end else if (s.txbit == SFP_TX_LAST_BIT) begin
            next_s.txbusy = 1'b0;
         end else begin
            next_s.txd   = s.txsh[0];
            next_s.txsh  = {1'b1, s.txsh[8:1]};
            next_s.txbit = s.txbit + 4'h1;
            next_s.txbd  = BD_FULL;
         end

         // Receiver
         next_s.rxs1 = rxd;
         next_s.rxs2 = s.rxs1;
         // (R4) Receive enable gates framing
         if (!s.ctrl[SFP_CTL_RX_ON]) begin
            next_s.rxbusy = 1'b0;
         end else if (!s.rxbusy) begin
            if (!s.rxs2) begin
               next_s.rxbusy = 1'b1;
               next_s.rxbit  = 4'h0;
               next_s.rxbd   = BD_HALF;
            end
         end else if (s.rxbd != 16'h0000) begin
            next_s.rxbd = s.rxbd - 16'h0001;
         end else begin
            next_s.rxbd  = BD_FULL;
            next_s.rxbit = s.rxbit + 4'h1;
            if (s.rxbit == 4'h0) begin
               // A start bit that does not hold is a glitch
               if (s.rxs2) begin
                  next_s.rxbusy = 1'b0;
               end
            end else if (s.rxbit == SFP_RX_STOP_BIT) begin
               next_s.rxbusy = 1'b0;
               if (s.rxs2) begin
                  next_s.rxdat  = s.rxsh;
                  next_s.rxfull = 1'b1;
               end else if (s.rxsh == 8'h00) begin
                  next_s.brk = 1'b1;
               end else begin
                  next_s.ferr = 1'b1;
               end
            end else begin
               next_s.rxsh = {s.rxs2, s.rxsh[7:1]};
            end
         end
      end

      // Register writes land on the accepting edge
      if (wr_go) begin
         unique case (avs_address)
            SFP_OFF_CTRL:
               next_s.ctrl = (s.ctrl & ~bmask[15:0])
                             | (avs_writedata[15:0] & bmask[15:0] & SFP_CTRL_MASK);
            SFP_OFF_MSTOP:
               if (avs_byteenable[0]) begin
                  next_s.mstop = avs_writedata[7:0];
               end
            SFP_OFF_TXDATA:
               // (R10) Full FIFO drops the write
               if (avs_byteenable[0] && next_s.cnt != CNT_MAX) begin
                  next_s.mem[s.wp] = avs_writedata[7:0];
                  next_s.wp        = s.wp + 4'h1;
                  next_s.cnt       = next_s.cnt + 5'h01;
               end
            SFP_OFF_TRIG:
               if (avs_byteenable[0]) begin
                  next_s.trig = avs_writedata[4:0];
               end
            SFP_OFF_ISTAT:
               if (avs_byteenable[0]) begin
                  next_s.istat = s.istat & ~avs_writedata[3:0];
               end
            SFP_OFF_IMASK:
               if (avs_byteenable[0]) begin
                  next_s.imask = avs_writedata[3:0];
               end
            default: ;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle
      next_s.istat = next_s.istat | req;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         s        <= '0;
         s.ctrl   <= SFP_CTRL_RESET;
         s.mstop  <= SFP_MSTOP_RESET;
         s.trig   <= SFP_TRIG_RESET;
         s.txd    <= 1'b1;
         s.rxs1   <= 1'b1;
         s.rxs2   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

endmodule // sfp_port

//--- test/sfp_props.sv
// Checker of the serial FIFO port control block
`timescale 1ns/100ps
module sfp_props
   import sfp_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        txd,
   input wire logic        sck_out,
   input wire logic        sck_oe,
   input wire logic        tx_low_irq,
   input wire logic        rx_fifo_full_irq,
   input wire logic        rx_fault_irq,
   input wire logic        line_break_irq
);
   // ------
   // Shadow of control and stop, taken where the bus write lands
   // ------
   logic [7:0] ctl;
   logic       stp;
   wire        wdone = avs_write && !avs_waitrequest;
   wire        rdctl = avs_read && !avs_waitrequest && avs_address == SFP_OFF_CTRL;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl <= 8'h00;
         stp <= 1'b0;
      end else if (wdone && avs_address == SFP_OFF_CTRL) begin
         ctl <= avs_writedata[7:0];
      end else if (wdone && avs_address == SFP_OFF_MSTOP) begin
         stp <= avs_writedata[SFP_MSTOP_SERIAL_UNIT];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_TXLOW_EN: assert property (tx_low_irq |-> ctl[7] && !stp)
      else $error("tx low request while disabled");
   AST_RX_EN: assert property (rx_fifo_full_irq || rx_fault_irq || line_break_irq |-> ctl[6])
      else $error("receive request while disabled");
   AST_FAULT_EN: assert property (rx_fault_irq || line_break_irq |-> ctl[3])
      else $error("fault request while disabled");
   // Register stage of the line allows one cycle after the write
   AST_TX_GATE: assert property (!ctl[5] ##1 !ctl[5] |-> txd)
      else $error("line driven while transmit off");
   AST_RX_OFF: assert property ($rose(rx_fifo_full_irq) && $past(ctl[6]) && !$past(stp) |-> ctl[4])
      else $error("frame taken while receive off");
   AST_SCK_IN: assert property (!sck_oe && !sck_out)
      else $error("clock pin driven");
   AST_STOP_HOLD: assert property (stp ##1 stp |-> $stable(txd))
      else $error("line moved while stopped");
   AST_CTRL_RD: assert property (rdctl |-> avs_readdata == {24'h0, ctl & SFP_CTRL_MASK[7:0]})
      else $error("control read back wrong");
   cover property (tx_low_irq ##1 !tx_low_irq);
   cover property (line_break_irq);
   cover property (!txd ##1 txd);
endmodule // sfp_props
bind sfp_port sfp_props i_sfp_props (.clk, .rstn, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .txd, .sck_out, .sck_oe, .tx_low_irq,
   .rx_fifo_full_irq, .rx_fault_irq, .line_break_irq);

//--- test/sfp_line.sv
// Remote serial device on the far side of the line
`timescale 1ns/100ps
module sfp_line #(
   parameter int BD = 4
) (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial rxd = 1'b1;
   // ------
   // Frame sender, idle line rests high
   // ------
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         rxd <= f[k];
         repeat (BD - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask
   // Samples mid bit on the falling clock, away from the launch edge
   always begin
      @(negedge txd);
      repeat (BD / 2) @(negedge clk);
      if (txd === 1'b0) begin
         for (int k = 0; k < 8; k++) begin
            repeat (BD) @(negedge clk);
            sh[k] = txd;
         end
         repeat (BD) @(negedge clk);
         if (txd === 1'b1) got.push_back(sh);
      end
   end
endmodule // sfp_line

//--- test/test_serial_fifo_port_control.sv
// Self-checking bench of the serial FIFO port control block
`timescale 1ns/100ps
module test_serial_fifo_port_control import sfp_pkg::*;;
   localparam int BD = 4;
   typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} sfp_row_t;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        sck_in = 1'b0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, txd, rxd, sck_out, sck_oe, irq;
   logic        tx_low_irq, rx_fifo_full_irq, rx_fault_irq, line_break_irq;
   int          error_cnt = 0;
   int          compares = 0;
   int          n;
   sfp_row_t    rows[7] = '{
      '{SFP_OFF_CTRL, 32'hFFFFFFFF, 32'hFB}, '{SFP_OFF_CTRL, 32'h4, 32'h0},
      '{SFP_OFF_TRIG, 32'hFFFFFFFF, 32'h1F}, '{SFP_OFF_IMASK, 32'hFFFFFFFF, 32'hF},
      '{8'h20, 32'hFFFFFFFF, 32'h0}, '{SFP_OFF_MSTOP, 32'hBF, 32'hBF},
      '{SFP_OFF_MSTOP, 32'h0, 32'h0}};

   sfp_port #(.BAUD_DIV(BD), .DEPTH(16)) i_sfp_port (.clk, .rstn, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .txd, .rxd, .sck_in, .sck_out, .sck_oe, .tx_low_irq, .rx_fifo_full_irq, .rx_fault_irq,
      .line_break_irq, .irq);
   sfp_line #(.BD(BD)) i_sfp_line (.clk, .txd, .rxd);

   always #12.5 clk = ~clk;
   // Clock pin toggles to show it is ignored
   always @(posedge clk) sck_in <= ~sck_in;

   // ------
   // Shared tasks
   // ------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Waitrequest and read data are taken at the rising edge, before it updates state
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= we;
      avs_read <= !we;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].wd);
         rdc("register", rows[i].a, rows[i].ex);
      end
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("ctrl reset", SFP_OFF_CTRL, 32'h0);
      rdc("trig reset", SFP_OFF_TRIG, {27'h0, SFP_TRIG_RESET});
      rdc("stop reset", SFP_OFF_MSTOP, 32'h0);
      chk("tx low off", 32'h0, tx_low_irq);
      bus(1'b1, SFP_OFF_CTRL, 32'h80);
      chk("tx low on", 32'h1, tx_low_irq);
      bus(1'b1, SFP_OFF_MSTOP, 32'h40);
      chk("stopped", 32'h0, tx_low_irq);
      bus(1'b1, SFP_OFF_MSTOP, 32'h0);
      chk("irq masked", 32'h0, irq);
      bus(1'b1, SFP_OFF_IMASK, 32'h1);
      chk("irq on", 32'h1, irq);
      bus(1'b1, SFP_OFF_CTRL, 32'h0);
      chk("irq sticky", 32'h1, irq);
      bus(1'b1, SFP_OFF_ISTAT, 32'h1);
      chk("irq clear", 32'h0, irq);
      for (int i = 0; i < 17; i++) bus(1'b1, SFP_OFF_TXDATA, 32'h30 + i);
      chk("txd idle", 32'h1, txd);
      bus(1'b0, SFP_OFF_LSTAT, 32'h0);
      chk("tx count", 32'h10, rd[12:8]);
      chk("below trig", 32'h0, rd[SFP_LS_TX_BELOW]);
      bus(1'b1, SFP_OFF_CTRL, 32'h20);
      bus(1'b0, SFP_OFF_LSTAT, 32'h0);
      chk("tx busy", 32'h0, rd[SFP_LS_TX_DONE]);
      n = 0;
      while (i_sfp_line.got.size() < 16 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      repeat (2 * BD) @(posedge clk);
      bus(1'b0, SFP_OFF_LSTAT, 32'h0);
      chk("tx done", 32'h1, rd[SFP_LS_TX_DONE]);
      chk("below trig", 32'h1, rd[SFP_LS_TX_BELOW]);
      chk("tx frames", 32'h10, i_sfp_line.got.size());
      for (int i = 0; i < 16; i++) chk("tx byte", 32'h30 + i, i_sfp_line.got[i]);
      bus(1'b1, SFP_OFF_CTRL, 32'h50);
      i_sfp_line.send(8'hA5, 1'b1);
      repeat (2 * BD) @(negedge clk);
      chk("rx full", 32'h1, rx_fifo_full_irq);
      rdc("rx data", SFP_OFF_RXDATA, 32'hA5);
      bus(1'b1, SFP_OFF_CTRL, 32'h40);
      i_sfp_line.send(8'h5A, 1'b1);
      repeat (2 * BD) @(negedge clk);
      chk("rx off", 32'h0, rx_fifo_full_irq);
      bus(1'b1, SFP_OFF_CTRL, 32'h50);
      i_sfp_line.send(8'h3C, 1'b0);
      i_sfp_line.send(8'h00, 1'b0);
      repeat (2 * BD) @(negedge clk);
      chk("faults masked", 32'h0, {rx_fault_irq, line_break_irq});
      bus(1'b1, SFP_OFF_CTRL, 32'h58);
      chk("faults on", 32'h3, {rx_fault_irq, line_break_irq});
      bus(1'b1, SFP_OFF_LSTAT, 32'h8);
      chk("fault clear", 32'h1, {rx_fault_irq, line_break_irq});
      bus(1'b1, SFP_OFF_CTRL, 32'h18);
      chk("rx irq off", 32'h0, {rx_fault_irq, line_break_irq});
      chk("sck pin", 32'h0, {sck_oe, sck_out});
      summarize();
   end
endmodule // test_serial_fifo_port_control
